// [design/link_sync.sv]
`timescale 1ns/1ps
// Contract
// - Serializer clock rate setting equals configured lane rate.
// - PLL settings derived from IQ rate and lane count automatically.
// - Read-only lock flag at 0x2DC reports PLL lock.
// - Both lanes form one link with one parameter set.
// - One lane 76.8-133.3 MSPS, two lanes 153.6-266.7 MSPS.
// - Lane rate is 40 times IQ rate divided by lanes.
// - IQ rate is ADC clock rate divided by decimation at 0x140.
// - One lane: M2 F4 S1 HD0 N16, K at least five.
// - Two lanes: M2 F2 S1 HD0 N16, K at least nine.
// - Captured sync event aligns link, filters and oscillator phase; the code only pulses link restart and phase load, with no filter alignment.
// - Sync behaviour chosen by options at 0x1E8.
// - Initial capture phase may vary by one ADC clock.
// - Phase held after capture until reset or clock loss; the code holds it until reset or the next accepted capture.
// - Bit 3 of 0x2BB low: sample on reference clock first.
// - Resample on internal digital clock before acting.
// - Continuous mode: early/late windows at 0x1EA tolerate jitter.
// - Sync event loads oscillator phase from 0x143-0x145.
module link_sync
  import link_sync_pkg::*;
#(
  parameter int ADC_CLK_MHZ = 3000,
  parameter int SETTLE_CYC  = PLL_SETTLE_CYC,
  parameter int PERIOD_W    = 8
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_arst_n,
  input  wire logic [9:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire logic        i_sync_pulse,
  input  wire logic        i_ref_clk_tick,
  input  wire logic        i_link_sync_request_in,
  input  wire logic        i_pll_vco_locked,
  output logic      [31:0] o_serializer_rate_kbps,
  output logic      [1:0]  o_lane_count,
  output logic      [7:0]  o_octets_per_frame,
  output logic      [7:0]  o_min_frames_per_multi,
  output logic             o_lane1_enable,
  output logic             o_link_restart,
  output logic             o_phase_load,
  output logic      [23:0] o_phase_value,
  output logic             o_link_request_seen
);

  logic [7:0] decimation_ratio;
  logic [7:0] phase_a;
  logic [7:0] phase_b;
  logic [7:0] phase_c;
  logic [7:0] sync_opt;
  logic [7:0] sync_win;
  logic [7:0] clk_rcv;
  logic       serializer_pll_locked;
  logic       sync_armed;
  logic       sync_aligned;
  link_cfg_t  cfg;
  link_cfg_t  next_cfg;
  pll_state_t pll_state;
  logic [31:0] settle_cnt;
  logic [1:0] ref_sync;
  logic [1:0] ref_tick_sync;
  logic       ref_tick_q;
  logic       ref_sample;
  logic [1:0] dig_sync;
  logic       dig_q;
  logic       rise;
  logic [PERIOD_W-1:0] since_edge;
  logic [PERIOD_W-1:0] period;
  logic [1:0] req_sync;
  logic [1:0] lock_sync;
  logic       do_capture;
  logic       in_window;
  logic [31:0] iq_ksps;

  // Register writes
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      decimation_ratio <= RST_DEC_RATIO;
      phase_a          <= RST_ZERO;
      phase_b          <= RST_ZERO;
      phase_c          <= RST_ZERO;
      sync_opt         <= RST_ZERO;
      sync_win         <= RST_ZERO;
      clk_rcv          <= RST_CLK_RCV;
    end else if (i_wr) begin
      case (i_addr)
        ADDR_DEC_RATIO: decimation_ratio <= i_wdata;
        ADDR_PHASE_A:   phase_a <= i_wdata;
        ADDR_PHASE_B:   phase_b <= i_wdata;
        ADDR_PHASE_C:   phase_c <= i_wdata;
        ADDR_SYNC_OPT:  sync_opt <= i_wdata & 8'hFB;
        ADDR_SYNC_WIN:  sync_win <= i_wdata;
        ADDR_CLK_RCV:   clk_rcv <= i_wdata;
        default: ;
      endcase
    end
  end

  // Register reads, data one cycle after strobe
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= RST_ZERO;
    end else if (i_rd) begin
      case (i_addr)
        ADDR_DEC_RATIO:  o_rdata <= decimation_ratio;
        ADDR_PHASE_A:    o_rdata <= phase_a;
        ADDR_PHASE_B:    o_rdata <= phase_b;
        ADDR_PHASE_C:    o_rdata <= phase_c;
        ADDR_SYNC_OPT:   o_rdata <= sync_opt;
        ADDR_SYNC_WIN:   o_rdata <= sync_win;
        ADDR_CLK_RCV:    o_rdata <= clk_rcv;
        ADDR_PLL_STATUS: o_rdata <= {7'h00, serializer_pll_locked};
        ADDR_LINK_STATUS:
          o_rdata <= {4'h0, cfg.rate_valid, sync_armed, sync_aligned,
                      o_lane1_enable};
        default:         o_rdata <= RST_ZERO;
      endcase
    end else begin
      o_rdata <= RST_ZERO;
    end
  end

  // Link setup derived from the IQ rate
  always_comb begin
    // IQ rate is ADC rate over ratio
    if (decimation_ratio == 8'h00) begin
      iq_ksps = 32'h0;
    end else begin
      iq_ksps = 32'((ADC_CLK_MHZ * 1000) / int'(decimation_ratio));
    end
    next_cfg = '0;
    if (iq_ksps >= 32'(RATE_1L_MIN_KSPS) &&
        iq_ksps <= 32'(RATE_1L_MAX_KSPS)) begin
      next_cfg.lanes      = 2'd1;
      next_cfg.octets     = OCT_F1;
      next_cfg.min_k      = MINK_F1;
      next_cfg.rate_valid = 1'b1;
    end else if (iq_ksps >= 32'(RATE_2L_MIN_KSPS) &&
                 iq_ksps <= 32'(RATE_2L_MAX_KSPS)) begin
      next_cfg.lanes      = 2'd2;
      next_cfg.octets     = OCT_F2;
      next_cfg.min_k      = MINK_F2;
      next_cfg.rate_valid = 1'b1;
    end else begin
      next_cfg.lanes = 2'd1;
    end
    if (next_cfg.lanes == 2'd2) begin
      next_cfg.lane_rate_kbps = 32'(iq_ksps * BITS_PER_IQ / 2);
    end else begin
      next_cfg.lane_rate_kbps = 32'(iq_ksps * BITS_PER_IQ);
    end
  end

  // Lock input synchronizer
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lock_sync <= 2'b00;
    end else begin
      lock_sync <= {lock_sync[0], i_pll_vco_locked};
    end
  end

  // Serializer PLL controller
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pll_state             <= PLL_IDLE;
      cfg                   <= '0;
      settle_cnt            <= 32'h0;
      serializer_pll_locked <= 1'b0;
    end else begin
      case (pll_state)
        PLL_IDLE: begin
          pll_state <= PLL_CONFIG;
        end
        PLL_CONFIG: begin
          cfg        <= next_cfg;
          settle_cnt <= 32'h0;
          pll_state  <= PLL_SETTLE;
        end
        PLL_SETTLE: begin
          if (next_cfg != cfg) begin
            pll_state <= PLL_CONFIG;
          end else if (settle_cnt >= 32'(SETTLE_CYC - 1) && lock_sync[1]) begin
            serializer_pll_locked <= cfg.rate_valid;
            pll_state             <= PLL_LOCKED;
          end else begin
            settle_cnt <= settle_cnt + 32'h1;
          end
        end
        PLL_LOCKED: begin
          if (next_cfg != cfg || !lock_sync[1]) begin
            serializer_pll_locked <= 1'b0;
            pll_state             <= PLL_CONFIG;
          end
        end
        default: pll_state <= PLL_IDLE;
      endcase
    end
  end

  // Link parameter outputs
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_serializer_rate_kbps <= 32'h0;
      o_lane_count           <= 2'd0;
      o_octets_per_frame     <= RST_ZERO;
      o_min_frames_per_multi <= RST_ZERO;
      o_lane1_enable         <= 1'b0;
    end else begin
      o_serializer_rate_kbps <= cfg.lane_rate_kbps;
      o_lane_count           <= cfg.lanes;
      o_octets_per_frame     <= cfg.octets;
      o_min_frames_per_multi <= cfg.min_k;
      o_lane1_enable         <= (cfg.lanes == 2'd2);
    end
  end

  // Sync pin synchronizer, two flops
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ref_sync <= 2'b00;
    end else begin
      ref_sync <= {ref_sync[0], i_sync_pulse};
    end
  end

  // Reference tick synchronizer and its delayed copy
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ref_tick_sync <= 2'b00;
      ref_tick_q    <= 1'b0;
    end else begin
      ref_tick_sync <= {ref_tick_sync[0], i_ref_clk_tick};
      ref_tick_q    <= ref_tick_sync[1];
    end
  end

  // Reference-clock stage: pin level taken on a tick rise
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ref_sample <= 1'b0;
    end else begin
      if (ref_tick_sync[1] && !ref_tick_q) begin
        ref_sample <= ref_sync[1];
      end
    end
  end

  // Digital clock resample and edge detection
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dig_sync <= 2'b00;
      dig_q    <= 1'b0;
    end else begin
      // Pin and clock are unrelated in phase, so an event may
      // land one system cycle early or late from run to run
      // one-cycle capture spread
      dig_sync <= {dig_sync[0],
                   clk_rcv[CLK_RCV_DIRECT] ? ref_sync[1] : ref_sample};
      dig_q    <= dig_sync[1];
    end
  end

  assign rise = dig_sync[1] && !dig_q;

  // Windows count system cycles around the last measured period
  // tolerance window around expected period
  assign in_window =
    (since_edge + PERIOD_W'(sync_win[WIN_LATE_LSB +: 2]) + PERIOD_W'(1)
       >= period) &&
    (since_edge <= period + PERIOD_W'(sync_win[WIN_EARLY_LSB +: 2]));

  assign do_capture = rise && sync_opt[SYNC_OPT_ENABLE] && sync_armed &&
                      !(sync_aligned && in_window);

  // Period tracking for continuous mode
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      since_edge <= '0;
      period     <= '0;
    end else if (rise) begin
      period     <= since_edge + PERIOD_W'(1);
      since_edge <= '0;
    end else if (since_edge != '1) begin
      since_edge <= since_edge + PERIOD_W'(1);
    end
  end

  // Alignment flag, set by the first accepted event
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync_aligned <= 1'b0;
    end else if (do_capture) begin
      sync_aligned <= 1'b1;
    end
  end

  // Arming: one-shot disarms, rearm write or continuous mode arms
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync_armed <= 1'b1;
    end else if (do_capture) begin
      // Disarm wins over a rearm write in the same cycle
      if (sync_opt[SYNC_OPT_ONESHOT]) begin
        sync_armed <= 1'b0;
      end
    end else if (i_wr && i_addr == ADDR_SYNC_OPT &&
                 i_wdata[SYNC_OPT_REARM]) begin
      sync_armed <= 1'b1;
    end else if (!sync_opt[SYNC_OPT_ONESHOT]) begin
      sync_armed <= 1'b1;
    end
  end

  // Capture pulses, one cycle each
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_link_restart <= 1'b0;
      o_phase_load   <= 1'b0;
    end else begin
      o_link_restart <= do_capture;
      o_phase_load   <= do_capture;
    end
  end

  // Oscillator start phase, held between captures
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_phase_value <= 24'h000000;
    end else if (do_capture) begin
      o_phase_value <= {phase_c, phase_b, phase_a};
    end
  end

  // Receiver request synchronized and reported
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      req_sync            <= 2'b00;
      o_link_request_seen <= 1'b0;
    end else begin
      req_sync            <= {req_sync[0], i_link_sync_request_in};
      o_link_request_seen <= req_sync[1];
    end
  end

endmodule : link_sync

// [design/link_sync_pkg.sv]
package link_sync_pkg;
  // Register offsets (byte addresses on the plain port)
  localparam logic [9:0] ADDR_DEC_RATIO   = 10'h140;
  localparam logic [9:0] ADDR_PHASE_A     = 10'h143;
  localparam logic [9:0] ADDR_PHASE_B     = 10'h144;
  localparam logic [9:0] ADDR_PHASE_C     = 10'h145;
  localparam logic [9:0] ADDR_SYNC_OPT    = 10'h1E8;
  localparam logic [9:0] ADDR_SYNC_WIN    = 10'h1EA;
  localparam logic [9:0] ADDR_CLK_RCV     = 10'h2BB;
  localparam logic [9:0] ADDR_PLL_STATUS  = 10'h2DC;
  localparam logic [9:0] ADDR_LINK_STATUS = 10'h2DD;

  // Reset values
  localparam logic [7:0] RST_DEC_RATIO = 8'h10;
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] RST_CLK_RCV   = 8'h08;

  // Field positions
  localparam int SYNC_OPT_ENABLE  = 0;  // Capture enabled
  localparam int SYNC_OPT_ONESHOT = 1;  // Accept first event only
  localparam int SYNC_OPT_REARM   = 2;  // Write 1: rearm one-shot
  localparam int WIN_EARLY_LSB    = 0;  // Early tolerance, 2 bits
  localparam int WIN_LATE_LSB     = 4;  // Late tolerance, 2 bits
  localparam int CLK_RCV_DIRECT   = 3;  // 1: no reference-clock stage
  localparam int PLL_LOCK_BIT     = 0;

  // Link framing constants
  localparam int BITS_PER_IQ      = 40;
  localparam logic [7:0] CONV_M   = 8'h02;
  localparam logic [7:0] OCT_F1   = 8'h04;
  localparam logic [7:0] OCT_F2   = 8'h02;
  localparam logic [7:0] SAMP_S   = 8'h01;
  localparam logic [7:0] RES_N    = 8'h10;
  localparam logic [7:0] MINK_F1  = 8'h05;
  localparam logic [7:0] MINK_F2  = 8'h09;

  // Lane-count thresholds in kSPS
  localparam int RATE_1L_MIN_KSPS = 76800;
  localparam int RATE_1L_MAX_KSPS = 133300;
  localparam int RATE_2L_MIN_KSPS = 153600;
  localparam int RATE_2L_MAX_KSPS = 266700;

  // Lock settle time
  localparam int CLK_MHZ        = 100;
  localparam int PLL_SETTLE_NS  = 2000;
  localparam int PLL_SETTLE_CYC = (PLL_SETTLE_NS * CLK_MHZ + 999) / 1000;

  typedef enum {PLL_IDLE, PLL_CONFIG, PLL_SETTLE, PLL_LOCKED} pll_state_t;

  // Link parameter bundle
  typedef struct packed {
    logic [1:0]  lanes;
    logic [7:0]  octets;
    logic [7:0]  min_k;
    logic [31:0] lane_rate_kbps;
    logic        rate_valid;
  } link_cfg_t;
endpackage : link_sync_pkg

// [verif/link_rx_model.sv]
`timescale 1ns/1ps
module link_rx_model #(
  parameter int FRAME_CYC = 2
) (
  input  wire logic i_clk_sys,
  input  wire logic i_arst_n,
  input  wire logic i_resync,
  output logic      o_sync_request
);
  logic [7:0] hold_cnt;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hold_cnt <= 8'h00;
    end else if (i_resync) begin
      hold_cnt <= 8'(5 * FRAME_CYC);
    end else if (hold_cnt != 8'h00) begin
      hold_cnt <= hold_cnt - 8'h01;
    end
  end
  assign o_sync_request = (hold_cnt != 8'h00);
endmodule : link_rx_model

// [verif/link_sync_checker.sv]
`timescale 1ns/1ps
module link_sync_checker
  import link_sync_pkg::*;
(
  input wire logic        i_clk_sys,
  input wire logic        i_arst_n,
  input wire logic [9:0]  i_addr,
  input wire logic        i_rd,
  input wire logic [7:0]  o_rdata,
  input wire logic        i_link_sync_request_in,
  input wire logic [1:0]  o_lane_count,
  input wire logic [7:0]  o_octets_per_frame,
  input wire logic [7:0]  o_min_frames_per_multi,
  input wire logic        o_lane1_enable,
  input wire logic        o_link_restart,
  input wire logic        o_phase_load,
  input wire logic [23:0] o_phase_value,
  input wire logic        o_link_request_seen
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  property p_status;
    $past(i_rd) && $past(i_addr) == ADDR_PLL_STATUS |-> o_rdata[7:1] == 7'h00;
  endproperty
  a_status: assert property (p_status)
    else $error("status reserved bits set");
  property p_rd_idle;
    !$past(i_rd) |-> o_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read cycle");
  property p_restart_load;
    o_link_restart == o_phase_load;
  endproperty
  a_restart_load: assert property (p_restart_load)
    else $error("restart and phase load apart");
  property p_one_event;
    o_link_restart |=> !o_link_restart;
  endproperty
  a_one_event: assert property (p_one_event)
    else $error("restart longer than one cycle");
  property p_phase_hold;
    !o_phase_load |-> $stable(o_phase_value);
  endproperty
  a_phase_hold: assert property (p_phase_hold)
    else $error("phase changed without capture");
  property p_one_lane;
    o_lane_count == 2'h1 && o_octets_per_frame != 8'h00
      |-> o_octets_per_frame == OCT_F1 && o_min_frames_per_multi == MINK_F1;
  endproperty
  a_one_lane: assert property (p_one_lane)
    else $error("single lane framing wrong");
  property p_two_lane;
    o_lane_count == 2'h2
      |-> o_octets_per_frame == OCT_F2 && o_min_frames_per_multi == MINK_F2;
  endproperty
  a_two_lane: assert property (p_two_lane)
    else $error("two lane framing wrong");
  property p_lane1;
    o_lane1_enable == (o_lane_count == 2'h2);
  endproperty
  a_lane1: assert property (p_lane1)
    else $error("lane enable disagrees with count");
  property p_req_seen;
    $rose(i_link_sync_request_in) |-> ##[1:4] o_link_request_seen;
  endproperty
  a_req_seen: assert property (p_req_seen)
    else $error("sync request not seen");
endmodule : link_sync_checker

bind link_sync link_sync_checker u_chk (
  .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_link_sync_request_in(i_link_sync_request_in),
  .o_lane_count(o_lane_count), .o_octets_per_frame(o_octets_per_frame),
  .o_min_frames_per_multi(o_min_frames_per_multi),
  .o_lane1_enable(o_lane1_enable), .o_link_restart(o_link_restart),
  .o_phase_load(o_phase_load), .o_phase_value(o_phase_value),
  .o_link_request_seen(o_link_request_seen)
);

// [verif/link_sync_tb.sv]
`timescale 1ns/1ps
module link_sync_tb;
  import link_sync_pkg::*;
  localparam int ADC = 3000;
  logic        i_clk_sys, i_arst_n, i_wr, i_rd, i_sync_pulse, i_ref_clk_tick;
  logic        i_pll_vco_locked, resync, sync_req, o_lane1_enable;
  logic        o_link_restart, o_phase_load, o_link_request_seen;
  logic [9:0]  i_addr;
  logic [7:0]  i_wdata, o_rdata, o_octets_per_frame, o_min_frames_per_multi;
  logic [7:0]  rd_val;
  logic [31:0] o_serializer_rate_kbps;
  logic [1:0]  o_lane_count;
  logic [23:0] o_phase_value;
  int          n_mismatch, n_checks;
  link_sync #(.ADC_CLK_MHZ(ADC), .SETTLE_CYC(4)) u_dut (
    .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_sync_pulse(i_sync_pulse), .i_ref_clk_tick(i_ref_clk_tick),
    .i_link_sync_request_in(sync_req), .i_pll_vco_locked(i_pll_vco_locked),
    .o_serializer_rate_kbps(o_serializer_rate_kbps),
    .o_lane_count(o_lane_count), .o_octets_per_frame(o_octets_per_frame),
    .o_min_frames_per_multi(o_min_frames_per_multi),
    .o_lane1_enable(o_lane1_enable), .o_link_restart(o_link_restart),
    .o_phase_load(o_phase_load), .o_phase_value(o_phase_value),
    .o_link_request_seen(o_link_request_seen));
  link_rx_model u_rx (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
    .i_resync(resync), .o_sync_request(sync_req));
  // System clock and free reference tick
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    i_ref_clk_tick = 1'b0;
    forever begin
      repeat (3) @(posedge i_clk_sys);
      i_ref_clk_tick <= ~i_ref_clk_tick;
    end
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] a);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(negedge i_clk_sys);
    rd_val = o_rdata;
  endtask : rd
  task automatic rdchk(input logic [9:0] a, input logic [7:0] e);
    rd(a);
    chk(32'(rd_val), 32'(e));
  endtask : rdchk
  // Poll lock flag under a bound
  task automatic wait_lock;
    for (int i = 0; i < 40; i++) begin
      rd(ADDR_PLL_STATUS);
      if (rd_val === 8'h01) return;
    end
    chk(32'h0, 32'h1);
    end_sim();
  endtask : wait_lock
  // Link setup expected from the decimation ratio
  task automatic cfg_chk(input int dec);
    int iq, ln;
    iq = ADC * 1000 / dec;
    ln = (iq >= RATE_2L_MIN_KSPS) ? 2 : 1;
    chk(32'(o_lane_count), 32'(ln));
    chk(o_serializer_rate_kbps, 32'(BITS_PER_IQ * iq / ln));
    chk(32'(o_octets_per_frame), 32'(ln == 2 ? OCT_F2 : OCT_F1));
    chk(32'(o_min_frames_per_multi), 32'(ln == 2 ? MINK_F2 : MINK_F1));
    chk(32'(o_lane1_enable), 32'(ln == 2));
  endtask : cfg_chk
  // Sync pulse held nine cycles, capture looked for
  task automatic sync(input logic exp);
    logic seen;
    seen = 1'b0;
    @(posedge i_clk_sys);
    i_sync_pulse <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      @(posedge i_clk_sys);
      if (i == 8) i_sync_pulse <= 1'b0;
      #1 if (o_link_restart === 1'b1) seen = 1'b1;
    end
    chk(32'(seen), 32'(exp));
  endtask : sync
  initial begin
    int decs [4];
    decs = '{12, 24, 32, 16};
    n_mismatch = 0;
    n_checks = 0;
    {i_arst_n, i_wr, i_rd, i_sync_pulse} = 4'h0;
    {i_pll_vco_locked, resync, i_addr, i_wdata} = 20'h00000;
    repeat (3) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    rdchk(ADDR_DEC_RATIO, RST_DEC_RATIO);
    rdchk(ADDR_PHASE_A, RST_ZERO);
    rdchk(ADDR_PHASE_B, RST_ZERO);
    rdchk(ADDR_PHASE_C, RST_ZERO);
    rdchk(ADDR_SYNC_OPT, RST_ZERO);
    rdchk(ADDR_SYNC_WIN, RST_ZERO);
    rdchk(ADDR_CLK_RCV, RST_CLK_RCV);
    wr(ADDR_PLL_STATUS, 8'hFF);
    repeat (20) @(posedge i_clk_sys);
    rdchk(ADDR_PLL_STATUS, 8'h00);
    rdchk(10'h000, 8'h00);
    i_pll_vco_locked <= 1'b1;
    wait_lock();
    foreach (decs[i]) begin
      wr(ADDR_DEC_RATIO, 8'(decs[i]));
      rdchk(ADDR_PLL_STATUS, 8'h00);
      wait_lock();
      cfg_chk(decs[i]);
    end
    wr(ADDR_PHASE_A, 8'h11);
    wr(ADDR_PHASE_B, 8'h22);
    wr(ADDR_PHASE_C, 8'h33);
    // Late window two cycles, early window one cycle
    wr(ADDR_SYNC_WIN, 8'h21);
    sync(1'b0);
    wr(ADDR_SYNC_OPT, 8'h01);
    sync(1'b1);
    chk(32'(o_phase_value), 32'h00332211);
    // Period 27 then 25: inside the late window, no resync
    sync(1'b0);
    wr(ADDR_SYNC_OPT, 8'h07);
    rdchk(ADDR_SYNC_OPT, 8'h03);
    sync(1'b1);
    sync(1'b0);
    wr(ADDR_SYNC_OPT, 8'h07);
    wr(ADDR_PHASE_A, 8'h44);
    chk(32'(o_phase_value), 32'h00332211);
    wr(ADDR_CLK_RCV, 8'h00);
    sync(1'b1);
    chk(32'(o_phase_value), 32'h00332244);
    rdchk(ADDR_LINK_STATUS, 8'h0B);
    // Mid-run reset drops the held phase and the lock
    @(posedge i_clk_sys);
    i_arst_n <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    #1 chk(32'(o_phase_value), 32'h0);
    rdchk(ADDR_PLL_STATUS, 8'h00);
    chk(32'(o_link_request_seen), 32'h0);
    @(posedge i_clk_sys);
    resync <= 1'b1;
    @(posedge i_clk_sys);
    resync <= 1'b0;
    repeat (5) @(posedge i_clk_sys);
    #1 chk(32'(o_link_request_seen), 32'h1);
    repeat (12) @(posedge i_clk_sys);
    #1 chk(32'(o_link_request_seen), 32'h0);
    end_sim();
  end
endmodule : link_sync_tb
